/* File: core/cas_regs.sv */
// Clock alarm and status register bank with free-run divider setting.
// Assumes a serial port engine on i_ref_clk issuing byte reads and writes;
// alarm inputs come from the analog side and are synchronised here.
`timescale 1ns/1ps
// Notes on behaviour
// - The free-run divider keeps bits 15:8 at one offset and 7:0 at the next, ratio is value+1.
// - Active-input bit reads 1 while the input clock pin feeds the PLL, 0 if unselected or lost.
// - Bit 1 of the live loss register shows loss of signal on the input clock pin.
// - Bit 0 of the live loss register shows loss of signal on the reference crystal pins.
// - Bit 0 of the live lock register reads 0 when locked and 1 when unlocked.
// - Input loss sticky flag at bit 1 sets on the live alarm and holds until written 0.
// - Input loss flag drives the interrupt only with the pin enable set and its mask clear.
// - Reference loss sticky flag at bit 0 sets on the live alarm and holds until written 0.
// - Reference loss flag drives the interrupt only with the pin enable set and its mask clear.
// - Lock loss sticky flag at bit 1 sets on the live alarm and holds until written 0.
// - Lock loss flag drives the interrupt only with the pin enable set and its mask clear.
// - A 4-bit revision code sits in the low nibble beside it; codes above 0010 are reserved.
module cas_regs
    import cas_pkg::*;
#(
    parameter logic [11:0] PART_ID = 12'h5A5, // Arbitrary value
    parameter logic [3:0] REV_ID = 4'h0
) (
    input wire logic i_ref_clk, // 200 MHz reference clock
    input wire logic i_rst, // Synchronous reset, high
    input wire logic [7:0] i_reg_addr, // Register offset
    input wire logic i_reg_wr, // Write strobe, one cycle
    input wire logic [7:0] i_reg_wdata, // Write data
    input wire logic i_reg_rd, // Read strobe, one cycle
    output logic [7:0] o_reg_rdata, // Read data, registered
    output logic o_reg_rvalid, // Read data valid, one cycle
    input wire logic i_input_selected, // Input clock pin selected, async
    input wire logic i_input_signal_loss, // Input clock pin loss, async
    input wire logic i_reference_signal_loss, // Reference pins loss, async
    input wire logic i_lock_loss, // PLL unlocked, async
    input wire logic i_input_loss_mask, // Mask for input loss flag
    input wire logic i_reference_loss_mask, // Mask for reference loss flag
    input wire logic i_lock_loss_mask, // Mask for lock loss flag
    input wire logic i_int_pin_en, // Interrupt pin enable
    output logic [15:0] o_freerun_ref_divider, // Divider low 16 bits
    output logic o_int // Interrupt, active high
);
    initial begin
        if (REV_ID > CAS_REV_MAX) begin
            $error("cas_regs: REV_ID is a reserved revision code");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers, first stage read by the second and by the a_ref_follow check
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    // Reset to the documented live readings: input lost, reference ok, unlocked
    localparam logic [3:0] SYNC_RST = 4'hA;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
        end else begin
            sync1_q <= {i_lock_loss, i_input_selected, i_input_signal_loss,
                        i_reference_signal_loss};
            sync2_q <= sync1_q;
        end
    end

    logic input_loss_live;
    logic reference_loss_live;
    logic input_selected;
    logic lock_live;
    logic input_active;
    assign reference_loss_live = sync2_q[0];
    assign input_loss_live = sync2_q[1];
    assign input_selected = sync2_q[2];
    assign lock_live = sync2_q[3];
    assign input_active = input_selected & ~input_loss_live;

    ////////////////////////////////////////////////////////////////////////////
    // Free-run divider, hardware divides by value plus one
    logic [7:0] div_mid_q;
    logic [7:0] div_low_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            div_mid_q <= CAS_RST_DIV_MID;
            div_low_q <= CAS_RST_DIV_LOW;
        end else if (i_reg_wr) begin
            if (i_reg_addr == CAS_ADDR_DIV_MID) begin
                div_mid_q <= i_reg_wdata;
            end
            if (i_reg_addr == CAS_ADDR_DIV_LOW) begin
                div_low_q <= i_reg_wdata;
            end
        end
    end

    assign o_freerun_ref_divider = {div_mid_q, div_low_q};

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags: [1] input loss, [0] reference loss, and lock loss
    logic [1:0] sig_flags;
    logic [0:0] lock_flag;
    logic sig_wr;
    logic lock_wr;
    assign sig_wr = i_reg_wr && (i_reg_addr == CAS_ADDR_SIG_STICKY);
    assign lock_wr = i_reg_wr && (i_reg_addr == CAS_ADDR_LOCK_STICKY);

    cas_sticky_flags #(
        .W(2),
        .RST_VAL(CAS_RST_SIG_STICKY[1:0])
    ) u_sig_flags (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_set({input_loss_live, reference_loss_live}),
        .i_wr(sig_wr),
        .i_wdata(i_reg_wdata[1:0]),
        .o_flags(sig_flags)
    );

    cas_sticky_flags #(
        .W(1),
        .RST_VAL(CAS_RST_LOCK_STICKY[CAS_BIT_LOCK_STICKY])
    ) u_lock_flag (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_set(lock_live),
        .i_wr(lock_wr),
        .i_wdata(i_reg_wdata[CAS_BIT_LOCK_STICKY]),
        .o_flags(lock_flag)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt, registered so the pin never glitches on mask changes
    logic int_d;
    assign int_d = i_int_pin_en & (
        (sig_flags[CAS_BIT_INPUT_LOSS] & ~i_input_loss_mask) |
        (sig_flags[CAS_BIT_REF_LOSS] & ~i_reference_loss_mask) |
        (lock_flag[0] & ~i_lock_loss_mask));

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_int <= 1'b0;
        end else begin
            o_int <= int_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; reserved bits come from the reset images
    function automatic logic [7:0] merge(input logic [7:0] rst_img, input logic [7:0] mask,
                                         input logic [7:0] live);
        merge = (rst_img & ~mask) | (live & mask);
    endfunction

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_reg_rdata <= CAS_UNMAPPED_DATA;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                unique case (i_reg_addr)
                    CAS_ADDR_DIV_MID: o_reg_rdata <= div_mid_q;
                    CAS_ADDR_DIV_LOW: o_reg_rdata <= div_low_q;
                    CAS_ADDR_ACTIVE: o_reg_rdata <= merge(CAS_RST_ACTIVE, 8'h01,
                        {7'h00, input_active});
                    CAS_ADDR_SIG_LIVE: o_reg_rdata <= merge(CAS_RST_SIG_LIVE, 8'h03,
                        {6'h00, input_loss_live, reference_loss_live});
                    CAS_ADDR_LOCK_LIVE: o_reg_rdata <= merge(CAS_RST_LOCK_LIVE, 8'h01,
                        {7'h00, lock_live});
                    CAS_ADDR_SIG_STICKY: o_reg_rdata <= merge(CAS_RST_SIG_STICKY, 8'h03,
                        {6'h00, sig_flags});
                    CAS_ADDR_LOCK_STICKY: o_reg_rdata <= merge(CAS_RST_LOCK_STICKY, 8'h02,
                        {6'h00, lock_flag, 1'b0});
                    CAS_ADDR_ID_HIGH: o_reg_rdata <= PART_ID[11:4];
                    CAS_ADDR_ID_LOW_REV: o_reg_rdata <= {PART_ID[3:0], REV_ID};
                    default: o_reg_rdata <= CAS_UNMAPPED_DATA;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_div_write;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_reg_wr && i_reg_addr == CAS_ADDR_DIV_LOW)
            |=> o_freerun_ref_divider[7:0] == $past(i_reg_wdata);
    endproperty
    a_div_write: assert property (p_div_write) else $error("divider low not written");

    property p_active_read;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == CAS_ADDR_ACTIVE)
            |=> o_reg_rvalid && o_reg_rdata == {7'h10, $past(input_selected & ~input_loss_live)};
    endproperty
    a_active_read: assert property (p_active_read) else $error("active read wrong");

    property p_live_read;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == CAS_ADDR_SIG_LIVE)
            |=> o_reg_rdata == {6'h01, $past(sync2_q[1]), $past(sync2_q[0])};
    endproperty
    a_live_read: assert property (p_live_read) else $error("live loss read wrong");

    property p_ref_follow;
        @(posedge i_ref_clk) disable iff (i_rst)
        $rose(sync1_q[0]) |=> reference_loss_live;
    endproperty
    a_ref_follow: assert property (p_ref_follow) else $error("reference loss lost");

    property p_lock_read;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == CAS_ADDR_LOCK_LIVE)
            |=> o_reg_rdata == {7'h00, $past(lock_live)};
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock read wrong");

    property p_input_sticky;
        @(posedge i_ref_clk) disable iff (i_rst)
        (input_loss_live || (sig_flags[CAS_BIT_INPUT_LOSS] && !(sig_wr && !i_reg_wdata[1])))
            |=> sig_flags[CAS_BIT_INPUT_LOSS];
    endproperty
    a_input_sticky: assert property (p_input_sticky) else $error("input flag dropped");

    property p_ref_clear;
        @(posedge i_ref_clk) disable iff (i_rst)
        (sig_wr && !i_reg_wdata[0] && !reference_loss_live) |=> !sig_flags[CAS_BIT_REF_LOSS];
    endproperty
    a_ref_clear: assert property (p_ref_clear) else $error("reference flag not cleared");

    property p_lock_sticky;
        @(posedge i_ref_clk) disable iff (i_rst)
        (lock_live && lock_wr && !i_reg_wdata[1]) |=> lock_flag[0];
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock set lost to clear");

    property p_int_gate;
        @(posedge i_ref_clk) disable iff (i_rst)
        (!i_int_pin_en || (i_input_loss_mask && i_reference_loss_mask && i_lock_loss_mask))
            |=> !o_int;
    endproperty
    a_int_gate: assert property (p_int_gate) else $error("interrupt not gated");

    property p_int_ref;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_int_pin_en && sig_flags[0] && !i_reference_loss_mask) |=> o_int;
    endproperty
    a_int_ref: assert property (p_int_ref) else $error("reference interrupt missing");

    property p_int_lock;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_int_pin_en && lock_flag[0] && !i_lock_loss_mask) |=> o_int;
    endproperty
    a_int_lock: assert property (p_int_lock) else $error("lock interrupt missing");

    property p_id_read;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == CAS_ADDR_ID_LOW_REV)
            |=> o_reg_rdata == {PART_ID[3:0], REV_ID};
    endproperty
    a_id_read: assert property (p_id_read) else $error("identifier read wrong");

    property p_keep_on_one;
        @(posedge i_ref_clk) disable iff (i_rst)
        (sig_wr && i_reg_wdata[1:0] == 2'b11)
            |=> sig_flags == ($past(sig_flags) | $past(sync2_q[1:0]));
    endproperty
    a_keep_on_one: assert property (p_keep_on_one) else $error("write one changed flag");

    property p_ro_write;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_reg_wr && i_reg_addr == CAS_ADDR_ID_HIGH) |=> $stable(o_freerun_ref_divider);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write had effect");
endmodule

/* File: shared/cas_pkg.sv */
// Package for the clock alarm and status register bank.
// Assumes an 8-bit register address space reached by the serial port engine.
package cas_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] CAS_ADDR_DIV_MID = 8'h2F;
    localparam logic [7:0] CAS_ADDR_DIV_LOW = 8'h30;
    localparam logic [7:0] CAS_ADDR_ACTIVE = 8'h80;
    localparam logic [7:0] CAS_ADDR_SIG_LIVE = 8'h81;
    localparam logic [7:0] CAS_ADDR_LOCK_LIVE = 8'h82;
    localparam logic [7:0] CAS_ADDR_SIG_STICKY = 8'h83;
    localparam logic [7:0] CAS_ADDR_LOCK_STICKY = 8'h84;
    localparam logic [7:0] CAS_ADDR_ID_HIGH = 8'h86;
    localparam logic [7:0] CAS_ADDR_ID_LOW_REV = 8'h87;
    ////////////////////////////////////////////////////////////////////////////
    // Reset values, reserved bits read back from these
    localparam logic [7:0] CAS_RST_DIV_MID = 8'h00;
    localparam logic [7:0] CAS_RST_DIV_LOW = 8'h09;
    localparam logic [7:0] CAS_RST_ACTIVE = 8'h20;
    localparam logic [7:0] CAS_RST_SIG_LIVE = 8'h06;
    localparam logic [7:0] CAS_RST_LOCK_LIVE = 8'h01;
    localparam logic [7:0] CAS_RST_SIG_STICKY = 8'h1F;
    localparam logic [7:0] CAS_RST_LOCK_STICKY = 8'h02;
    localparam logic [7:0] CAS_UNMAPPED_DATA = 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CAS_BIT_ACTIVE = 0;
    localparam int CAS_BIT_INPUT_LOSS = 1;
    localparam int CAS_BIT_REF_LOSS = 0;
    localparam int CAS_BIT_LOCK_LIVE = 0;
    localparam int CAS_BIT_LOCK_STICKY = 1;
    ////////////////////////////////////////////////////////////////////////////
    // Identity and synchroniser
    localparam int CAS_PART_ID_W = 12;
    localparam int CAS_REV_W = 4;
    localparam logic [3:0] CAS_REV_MAX = 4'h2;
    localparam int CAS_SYNC_STAGES = 2;
endpackage

/* File: core/cas_sticky_flags.sv */
// Sticky alarm flags: set by a live level, cleared by writing zero.
// Assumes the set inputs are already synchronised to i_ref_clk.
`timescale 1ns/1ps
module cas_sticky_flags #(
    parameter int W = 2,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic i_ref_clk, // Reference clock
    input wire logic i_rst, // Synchronous reset, high
    input wire logic [W-1:0] i_set, // Live alarm levels
    input wire logic i_wr, // Write strobe to this register
    input wire logic [W-1:0] i_wdata, // Zero bits clear, one bits keep
    output logic [W-1:0] o_flags // Held flags
);
    initial begin
        if (W < 1) begin
            $error("cas_sticky_flags: W must be at least 1");
        end
    end

    // A set in the clearing cycle wins so no alarm is lost
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_flags <= RST_VAL;
        end else if (i_wr) begin
            o_flags <= (o_flags & i_wdata) | i_set;
        end else begin
            o_flags <= o_flags | i_set;
        end
    end
endmodule

/* File: bench/cas_host_model.sv */
// Configuration host model driving the register strobe port of the bank.
// Assumes one clock and a bank that answers reads one cycle after the strobe.
`timescale 1ns/1ps
module cas_host_model (
    input wire logic i_ref_clk, // Reference clock
    output logic [7:0] o_reg_addr, // Register offset
    output logic o_reg_wr, // Write strobe
    output logic [7:0] o_reg_wdata, // Write data
    output logic o_reg_rd, // Read strobe
    input wire logic [7:0] i_reg_rdata, // Read data
    input wire logic i_reg_rvalid // Read data valid
);
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_wdata = 8'h00;
        o_reg_rd = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Idle lines show the inverse of the last value, so stale data cannot pass
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_reg_wr <= 1'b1;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_ref_clk);
        o_reg_wr <= 1'b0;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge i_ref_clk);
        o_reg_rd <= 1'b1;
        o_reg_addr <= a;
        @(posedge i_ref_clk);
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
        for (int i = 0; i < 4; i++) begin
            #1;
            if (i_reg_rvalid === 1'b1) begin
                d = i_reg_rdata;
                ok = 1'b1;
                break;
            end
            @(posedge i_ref_clk);
        end
    endtask
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the clock alarm and status register bank.
// Assumes the host model as register partner; alarms are driven directly.
`timescale 1ns/1ps
module tb_top;
    import cas_pkg::*;
    localparam logic [11:0] TB_PART_ID = 12'h3C7; // Arbitrary value
    localparam logic [3:0] TB_REV_ID = 4'h1;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rvalid;
    logic in_sel = 1'b1, in_loss = 1'b1, ref_loss = 1'b0, lock_loss = 1'b1;
    logic [2:0] msk = 3'b111;
    logic int_en = 1'b0;
    logic [15:0] divider;
    logic irq;
    int num_errors = 0;
    int n_compared = 0;
    always #2.5 i_ref_clk = ~i_ref_clk;
    cas_host_model HOST (.i_ref_clk(i_ref_clk), .o_reg_addr(reg_addr), .o_reg_wr(reg_wr),
        .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd), .i_reg_rdata(reg_rdata),
        .i_reg_rvalid(reg_rvalid));
    cas_regs #(.PART_ID(TB_PART_ID), .REV_ID(TB_REV_ID)) DUT (.i_ref_clk(i_ref_clk),
        .i_rst(i_rst), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata),
        .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
        .i_input_selected(in_sel), .i_input_signal_loss(in_loss),
        .i_reference_signal_loss(ref_loss), .i_lock_loss(lock_loss),
        .i_input_loss_mask(msk[0]), .i_reference_loss_mask(msk[1]),
        .i_lock_loss_mask(msk[2]), .i_int_pin_en(int_en),
        .o_freerun_ref_divider(divider), .o_int(irq));
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        HOST.read(a, d, ok);
        if (ok !== 1'b1) begin
            num_errors++;
            $display("Error read valid at %h expected 1 seen 0", a);
            conclude();
        end else begin
            chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // Alarm order is {lock, reference, input}; waits cover the two-stage synchroniser
    task automatic set_alarms(input logic sel, input logic [2:0] a);
        @(posedge i_ref_clk);
        in_sel <= sel;
        {lock_loss, ref_loss, in_loss} <= a;
        cycles(6);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] addrs [10] = '{CAS_ADDR_DIV_MID, CAS_ADDR_DIV_LOW, CAS_ADDR_ACTIVE,
            CAS_ADDR_SIG_LIVE, CAS_ADDR_LOCK_LIVE, CAS_ADDR_SIG_STICKY, CAS_ADDR_LOCK_STICKY,
            CAS_ADDR_ID_HIGH, CAS_ADDR_ID_LOW_REV, 8'h85};
        logic [7:0] exps [10] = '{8'h00, 8'h09, 8'h20, 8'h06, 8'h01, 8'h1F, 8'h02,
            TB_PART_ID[11:4], {TB_PART_ID[3:0], TB_REV_ID}, 8'h00};
        chk("divider", 16'h0009, divider);
        for (int i = 0; i < 10; i++) begin
            rd_chk(addrs[i], exps[i]);
        end
    endtask
    task automatic t_divider();
        HOST.write(CAS_ADDR_DIV_MID, 8'hFF);
        HOST.write(CAS_ADDR_DIV_LOW, 8'hFE);
        cycles(1);
        chk("divider", 16'hFFFE, divider);
        rd_chk(CAS_ADDR_DIV_MID, 8'hFF);
        HOST.write(CAS_ADDR_DIV_MID, 8'h00);
        HOST.write(CAS_ADDR_DIV_LOW, 8'h00);
        cycles(1);
        chk("divider", 16'h0000, divider);
        rd_chk(CAS_ADDR_DIV_LOW, 8'h00);
    endtask
    task automatic t_read_only();
        logic [7:0] addrs [7] = '{CAS_ADDR_ACTIVE, CAS_ADDR_SIG_LIVE, CAS_ADDR_LOCK_LIVE,
            CAS_ADDR_SIG_STICKY, CAS_ADDR_LOCK_STICKY, CAS_ADDR_ID_HIGH, CAS_ADDR_ID_LOW_REV};
        logic [7:0] exps [7] = '{8'h20, 8'h06, 8'h01, 8'h1F, 8'h02, TB_PART_ID[11:4],
            {TB_PART_ID[3:0], TB_REV_ID}};
        for (int i = 0; i < 7; i++) begin
            HOST.write(addrs[i], 8'hFF);
            rd_chk(addrs[i], exps[i]);
        end
    endtask
    task automatic t_live();
        set_alarms(1'b1, 3'b000);
        rd_chk(CAS_ADDR_ACTIVE, 8'h21);
        rd_chk(CAS_ADDR_SIG_LIVE, 8'h04);
        rd_chk(CAS_ADDR_LOCK_LIVE, 8'h00);
        set_alarms(1'b0, 3'b000);
        rd_chk(CAS_ADDR_ACTIVE, 8'h20);
        set_alarms(1'b1, 3'b010);
        rd_chk(CAS_ADDR_SIG_LIVE, 8'h05);
        rd_chk(CAS_ADDR_ACTIVE, 8'h21);
        set_alarms(1'b1, 3'b001);
        rd_chk(CAS_ADDR_ACTIVE, 8'h20);
        rd_chk(CAS_ADDR_SIG_LIVE, 8'h06);
        set_alarms(1'b1, 3'b100);
        rd_chk(CAS_ADDR_LOCK_LIVE, 8'h01);
        set_alarms(1'b1, 3'b000);
    endtask
    // One flag at a time: raised, masked, unmasked, then the pin enable dropped
    task automatic t_sticky_int();
        logic [7:0] e83;
        HOST.write(CAS_ADDR_SIG_STICKY, 8'h00);
        HOST.write(CAS_ADDR_LOCK_STICKY, 8'h00);
        rd_chk(CAS_ADDR_SIG_STICKY, 8'h1C);
        rd_chk(CAS_ADDR_LOCK_STICKY, 8'h00);
        for (int k = 0; k < 3; k++) begin
            e83 = (k == 0) ? 8'h1E : ((k == 1) ? 8'h1D : 8'h1C);
            @(posedge i_ref_clk);
            msk <= 3'b111;
            int_en <= 1'b1;
            set_alarms(1'b1, 3'(1 << k));
            set_alarms(1'b1, 3'b000);
            rd_chk(CAS_ADDR_SIG_STICKY, e83);
            rd_chk(CAS_ADDR_LOCK_STICKY, (k == 2) ? 8'h02 : 8'h00);
            chk("masked irq", 16'h0000, {15'h0, irq});
            @(posedge i_ref_clk);
            msk <= ~3'(1 << k);
            cycles(3);
            chk("irq", 16'h0001, {15'h0, irq});
            @(posedge i_ref_clk);
            int_en <= 1'b0;
            cycles(3);
            chk("disabled irq", 16'h0000, {15'h0, irq});
            @(posedge i_ref_clk);
            int_en <= 1'b1;
            HOST.write(CAS_ADDR_SIG_STICKY, 8'h00);
            HOST.write(CAS_ADDR_LOCK_STICKY, 8'h00);
            cycles(3);
            chk("cleared irq", 16'h0000, {15'h0, irq});
        end
    endtask
    // Clearing while the alarm still stands must leave every flag set
    task automatic t_set_wins();
        set_alarms(1'b1, 3'b111);
        HOST.write(CAS_ADDR_SIG_STICKY, 8'h00);
        HOST.write(CAS_ADDR_LOCK_STICKY, 8'h00);
        rd_chk(CAS_ADDR_SIG_STICKY, 8'h1F);
        rd_chk(CAS_ADDR_LOCK_STICKY, 8'h02);
        set_alarms(1'b1, 3'b000);
        HOST.write(CAS_ADDR_SIG_STICKY, 8'h00);
        HOST.write(CAS_ADDR_LOCK_STICKY, 8'h00);
        rd_chk(CAS_ADDR_SIG_STICKY, 8'h1C);
        rd_chk(CAS_ADDR_LOCK_STICKY, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        cycles(3);
        t_reset();
        t_divider();
        t_read_only();
        t_live();
        t_sticky_int();
        t_set_wins();
        conclude();
    end
endmodule
